// ### tb_top.sv
// Purpose: self-checking bench of the call and flush check unit
// Assumes: mode and pointers set up through the register port
// Notes: expected results follow the check order of each instruction
`timescale 1ns/1ps
module tb_top import vcc_pkg::*;;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  logic wr_en;
  logic rd_en;
  logic busy;
  logic mgmt;
  logic done;
  logic saw_mgmt;
  logic [31:0] st;
  int mismatches = 0;
  int samples_checked = 0;

  always #25 clk = ~clk;

  vcc_sw_model i_sw (.clk(clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data));
  vcc_check_unit i_dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .busy(busy),
    .sys_mgmt_mode(mgmt), .done(done));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // one instruction: set mode, start, wait for done, fetch status
  task automatic tc(input logic [1:0] kind, input logic [31:0] mode, input vcc_res_e res);
    int n;
    n = 0;
    i_sw.wr(REG_MODE, mode);
    i_sw.wr(REG_CTRL, {30'h0, kind});
    saw_mgmt = 1'b0;
    do begin
      @(negedge clk);
      n++;
      saw_mgmt |= (mgmt === 1'b1);
    end while (done !== 1'b1 && n < 10);
    chk("done", 32'(n < 10), 32'h1);
    chk("busy", 32'(busy), 32'h0);
    i_sw.rd(REG_STATUS, st);
    chk("result", 32'(st[5:2]), 32'(res));
  endtask : tc

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end

  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    i_sw.wr(REG_OP_HI, 32'h0001_0000);
    tc(2'h1, 32'h15, R_UD);
    tc(2'h1, 32'h35, R_UD);
    i_sw.wr(REG_SEC_CAPS_HI, 32'h20);
    tc(2'h1, 32'h35, R_UD);
    i_sw.wr(REG_TAG_CAPS_HI, 32'h1);
    tc(2'h1, 32'h1035, R_SS);
    tc(2'h1, 32'h35, R_GP);
    tc(2'h2, 32'h34, R_UD);
    tc(2'h2, 32'h37, R_VM_EXIT);
    chk("exit", 32'(st[31:24]), 32'(EXIT_MONITOR_CALL));
    tc(2'h2, 32'hF5, R_GP);
    tc(2'h2, 32'h135, R_FAIL_INVALID);
    chk("cf", 32'(st[6]), 32'h1);
    tc(2'h3, 32'h835, R_UD);
    tc(2'h3, 32'h37, R_VM_EXIT);
    i_sw.wr(REG_CUR_LO, 32'h3000);
    i_sw.wr(REG_CUR_HI, 32'h0);
    i_sw.wr(REG_OP_HI, 32'h0);
    i_sw.wr(REG_OP_LO, 32'h3001);
    tc(2'h3, 32'h35, R_FAIL_VALID);
    chk("err", 32'(st[23:16]), 32'(ERR_FLUSH_BADADDR));
    chk("zf", 32'(st[7]), 32'h1);
    i_sw.wr(REG_EN_LO, 32'h3000);
    i_sw.wr(REG_OP_LO, 32'h3000);
    tc(2'h3, 32'h35, R_FAIL_VALID);
    chk("err", 32'(st[23:16]), 32'(ERR_FLUSH_ENPTR));
    i_sw.wr(REG_EN_LO, 32'h8000);
    i_sw.wr(REG_BASIC_CAPS_HI, 32'h1_0000);
    i_sw.wr(REG_OP_HI, 32'h1);
    tc(2'h3, 32'h35, R_FAIL_VALID);
    i_sw.wr(REG_OP_HI, 32'h0);
    tc(2'h3, 32'h35, R_SUCCESS);
    i_sw.rd(REG_CUR_LO, st);
    chk("cur_lo", st, 32'hFFFF_FFFF);
    i_sw.wr(REG_CUR_LO, 32'h3000);
    i_sw.wr(REG_CUR_HI, 32'h0);
    i_sw.wr(REG_MONITOR_SEGMENT_REV, 32'h2);
    tc(2'h2, 32'h60635, R_FAIL_VALID);
    chk("mgmt", 32'(saw_mgmt), 32'h1);
    i_sw.wr(REG_MONITOR_SEGMENT_REV, 32'h1);
    tc(2'h2, 32'h20635, R_FAIL_VALID);
    tc(2'h2, 32'h60635, R_SUCCESS);
    chk("dual", 32'(st[9]), 32'h1);
    tc(2'h2, 32'h60635, R_MGMT_EXIT);
    i_sw.wr(REG_CTRL, 32'h10);
    i_sw.wr(REG_LAUNCH, 32'h1);
    tc(2'h2, 32'h60635, R_FAIL_VALID);
    chk("err", 32'(st[23:16]), 32'(ERR_CALL_NONCLEAR));
    i_sw.wr(REG_LAUNCH, 32'h0);
    tc(2'h2, 32'h40635, R_FAIL_VALID);
    chk("err", 32'(st[23:16]), 32'(ERR_CALL_EXITCTL));
    tc(2'h2, 32'h0D, R_UD);
    tc(2'h3, 32'hC5, R_GP);
    tc(2'h3, 32'h2005, R_GP);
    tc(2'h3, 32'h3005, R_SS);
    tc(2'h3, 32'h8005, R_GP);
    tc(2'h3, 32'h10035, R_PF);
    test_done();
  end
endmodule : tb_top

// ### vcc_addr_if.sv
// Purpose: operand address and its check results between the check modules
// Assumes: one clock domain, purely combinational checks
// Notes: the main unit drives address and widths, checkers answer
`timescale 1ns/1ps
interface vcc_addr_if;
  logic [63:0] addr;
  logic [6:0] pa_bits;
  logic limit_32b;
  logic non_canon;
  logic bad_phys;
  modport user (output addr, output pa_bits, output limit_32b, input non_canon, input bad_phys);
  modport canon (input addr, output non_canon);
  modport phys (input addr, input pa_bits, input limit_32b, output bad_phys);
endinterface : vcc_addr_if

// ### vcc_canon_chk.sv
// Purpose: flags a linear address that is not in canonical form
// Assumes: LIN_BITS implemented linear bits
// Notes: bits above LIN_BITS-1 must all copy the top implemented bit
`timescale 1ns/1ps
module vcc_canon_chk #(
  parameter int LIN_BITS = 48
) (
  vcc_addr_if.canon a
);
  initial begin
    if (LIN_BITS < 32 || LIN_BITS > 63) $error("LIN_BITS out of range");
  end
  assign a.non_canon = !((&a.addr[63:LIN_BITS-1]) || (~|a.addr[63:LIN_BITS-1]));
endmodule : vcc_canon_chk

// ### vcc_check_unit.sv
// Purpose: fault checks and effects of tag invalidate, monitor call and block flush
// Assumes: core state and capabilities are mirrored into registers by software
// Notes: a control register write with a nonzero kind field, taken in idle, starts one instruction
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
module vcc_check_unit import vcc_pkg::*; #(
  parameter int PA_BITS = 36,
  parameter int SLOT_BITS = 4,
  parameter logic [31:0] MONITOR_SEGMENT_REVISION = 32'h0000_0001 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // core status
  output logic busy,
  output logic sys_mgmt_mode,
  output logic done
);
  initial begin
    if (PA_BITS < 32 || PA_BITS > 52) $error("PA_BITS out of range");
    if (SLOT_BITS < 1 || SLOT_BITS > 8) $error("SLOT_BITS out of range");
  end

  typedef enum logic [1:0] {S_IDLE, S_EVAL, S_REV, S_FEAT} vcc_state_e;

  vcc_state_e state, next_state;
  vcc_kind_e kind, next_kind;
  vcc_res_e res, next_res;
  logic [31:0] mode, next_mode, sec_hi, next_sec_hi, tag_hi, next_tag_hi;
  logic [31:0] basic_hi, next_basic_hi, monitor_segment_rev, next_monitor_segment_rev;
  logic [63:0] op, next_op, cur, next_cur, en_ptr, next_en_ptr;
  logic [7:0] err, next_err, exit_reason, next_exit_reason;
  logic done_q, next_done_q, mgmt, next_mgmt, dual, next_dual;
  logic [(1<<SLOT_BITS)-1:0] launched, next_launched;
  logic [31:0] next_rd_data;
  logic done_p, next_done_p;

  vcc_addr_if ai ();
  vcc_canon_chk #(.LIN_BITS(48)) u_canon (.a(ai));
  vcc_phys_chk u_phys (.a(ai));
  assign ai.addr = op;
  assign ai.pa_bits = 7'(PA_BITS);
  assign ai.limit_32b = basic_hi[CAP_BASIC_32B_BIT];

  // decoded core state
  logic virt_on, non_root, compat, long64, v86, cpl_nz, cur_valid, cur_launched;
  logic [SLOT_BITS-1:0] cur_slot, op_slot;
  assign virt_on = mode[MODE_VIRT_ON];
  assign non_root = mode[MODE_NON_ROOT];
  assign v86 = mode[MODE_V86];
  assign compat = mode[MODE_LMA] && !mode[MODE_CS_LONG];
  assign long64 = mode[MODE_LMA] && mode[MODE_CS_LONG];
  assign cpl_nz = |mode[MODE_CPL_LO +: 2];
  assign cur_valid = cur != PTR_INVALID;
  assign cur_slot = cur[12 +: SLOT_BITS];
  assign op_slot = op[12 +: SLOT_BITS];
  assign cur_launched = launched[cur_slot];

  logic wr_ctrl, wr_ok;
  assign wr_ok = wr_en && state == S_IDLE;
  assign wr_ctrl = wr_ok && addr == REG_CTRL;

  // instruction evaluation, first matching check wins
  vcc_res_e ev_res;
  logic [7:0] ev_err;
  logic ev_exit, ev_to_rev;
  always_comb begin
    ev_res = R_SUCCESS;
    ev_err = ERR_NONE;
    ev_exit = 1'b0;
    ev_to_rev = 1'b0;
    case (kind)
      K_TAG: begin
        if (!virt_on || !mode[MODE_PROT_EN] || v86 || compat) begin
          ev_res = R_UD;
        end else if (!sec_hi[CAP_SEC_TAG_BIT] || !tag_hi[CAP_TAG_INSTR_BIT]) begin
          ev_res = R_UD;
        end else if (non_root) begin
          ev_res = R_VM_EXIT;
        end else if (cpl_nz) begin
          ev_res = R_GP;
        end else if (long64 && ai.non_canon) begin
          ev_res = mode[MODE_STACK_SEG] ? R_SS : R_GP;
        end else if (mode[MODE_PAGE_FAULT]) begin
          ev_res = R_PF;
        end
      end
      K_CALL: begin
        if (!virt_on) begin
          ev_res = R_UD;
        end else if (non_root) begin
          ev_res = R_VM_EXIT;
          ev_exit = 1'b1;
        end else if (v86 || compat) begin
          ev_res = R_UD;
        end else if (cpl_nz) begin
          ev_res = R_GP;
        end else if (mode[MODE_SMM] || !mode[MODE_DUAL_SUP] || !mode[MODE_MONCTL_VALID]) begin
          ev_res = cur_valid ? R_FAIL_VALID : R_FAIL_INVALID;
          ev_err = cur_valid ? ERR_CALL_ROOT : ERR_NONE;
        end else if (dual) begin
          ev_res = R_MGMT_EXIT;
        end else if (!cur_valid) begin
          ev_res = R_FAIL_INVALID;
        end else if (cur_launched) begin
          ev_res = R_FAIL_VALID;
          ev_err = ERR_CALL_NONCLEAR;
        end else if (!mode[MODE_EXIT_CTL_OK]) begin
          ev_res = R_FAIL_VALID;
          ev_err = ERR_CALL_EXITCTL;
        end else begin
          ev_res = R_NONE;
          ev_to_rev = 1'b1;
        end
      end
      K_FLUSH: begin
        if (mode[MODE_REG_OPERAND] || !virt_on || !mode[MODE_PROT_EN] || v86 || compat) begin
          ev_res = R_UD;
        end else if (non_root) begin
          ev_res = R_VM_EXIT;
        end else if (cpl_nz) begin
          ev_res = R_GP;
        end else if (long64 && ai.non_canon) begin
          ev_res = mode[MODE_STACK_SEG] ? R_SS : R_GP;
        end else if (!long64 && (mode[MODE_SEG_LIMIT] || mode[MODE_SEG_UNUSABLE])) begin
          ev_res = mode[MODE_STACK_SEG] ? R_SS : R_GP;
        end else if (!long64 && mode[MODE_EXEC_ONLY]) begin
          ev_res = R_GP;
        end else if (mode[MODE_PAGE_FAULT]) begin
          ev_res = R_PF;
        end else if (ai.bad_phys) begin
          ev_res = cur_valid ? R_FAIL_VALID : R_FAIL_INVALID;
          ev_err = cur_valid ? ERR_FLUSH_BADADDR : ERR_NONE;
        end else if (op == en_ptr) begin
          ev_res = cur_valid ? R_FAIL_VALID : R_FAIL_INVALID;
          ev_err = cur_valid ? ERR_FLUSH_ENPTR : ERR_NONE;
        end
      end
      default: begin
        ev_res = R_NONE;
      end
    endcase
  end

  // sequencer and register file next values
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_res = res;
    next_err = err;
    next_exit_reason = exit_reason;
    next_done_q = done_q;
    next_done_p = 1'b0;
    next_mgmt = mgmt;
    next_dual = dual;
    next_mode = mode;
    next_sec_hi = sec_hi;
    next_tag_hi = tag_hi;
    next_basic_hi = basic_hi;
    next_monitor_segment_rev = monitor_segment_rev;
    next_op = op;
    next_cur = cur;
    next_en_ptr = en_ptr;
    next_launched = launched;
    if (wr_ok) begin
      if (wr_ctrl) begin
        if (wr_data[CTRL_DUAL_CLR]) begin
          next_dual = 1'b0;
        end
        if (wr_data[CTRL_KIND_LO +: 2] != 2'h0) begin
          next_kind = vcc_kind_e'(wr_data[CTRL_KIND_LO +: 2]);
          next_state = S_EVAL;
          next_done_q = 1'b0;
          next_res = R_NONE;
          next_err = ERR_NONE;
          next_exit_reason = 8'h00;
        end
      end else if (addr == REG_MODE) begin
        next_mode = wr_data;
      end else if (addr == REG_SEC_CAPS_HI) begin
        next_sec_hi = wr_data;
      end else if (addr == REG_TAG_CAPS_HI) begin
        next_tag_hi = wr_data;
      end else if (addr == REG_BASIC_CAPS_HI) begin
        next_basic_hi = wr_data;
      end else if (addr == REG_OP_LO) begin
        next_op[31:0] = wr_data;
      end else if (addr == REG_OP_HI) begin
        next_op[63:32] = wr_data;
      end else if (addr == REG_CUR_LO) begin
        next_cur[31:0] = wr_data;
      end else if (addr == REG_CUR_HI) begin
        next_cur[63:32] = wr_data;
      end else if (addr == REG_EN_LO) begin
        next_en_ptr[31:0] = wr_data;
      end else if (addr == REG_EN_HI) begin
        next_en_ptr[63:32] = wr_data;
      end else if (addr == REG_MONITOR_SEGMENT_REV) begin
        next_monitor_segment_rev = wr_data;
      end else if (addr == REG_LAUNCH) begin
        next_launched[cur_slot] = wr_data[0];
      end
    end
    case (state)
      S_EVAL: begin
        next_res = ev_res;
        next_err = ev_err;
        next_exit_reason = ev_exit ? EXIT_MONITOR_CALL : 8'h00;
        if (ev_to_rev) begin
          next_mgmt = 1'b1;
          next_state = S_REV;
        end else begin
          next_state = S_IDLE;
          next_done_q = 1'b1;
          next_done_p = 1'b1;
          if (kind == K_FLUSH && ev_res == R_SUCCESS) begin
            next_launched[op_slot] = 1'b0;
            if (op == cur) begin
              next_cur = PTR_INVALID;
            end
          end
        end
      end
      S_REV: begin
        if (monitor_segment_rev != MONITOR_SEGMENT_REVISION) begin
          next_mgmt = 1'b0;
          next_res = R_FAIL_VALID;
          next_err = ERR_CALL_MONITOR_SEGMENT_REV;
          next_state = S_IDLE;
          next_done_q = 1'b1;
          next_done_p = 1'b1;
        end else begin
          next_state = S_FEAT;
        end
      end
      S_FEAT: begin
        next_state = S_IDLE;
        next_done_q = 1'b1;
        next_done_p = 1'b1;
        if (!mode[MODE_FEAT_OK]) begin
          next_mgmt = 1'b0;
          next_res = R_FAIL_VALID;
          next_err = ERR_CALL_FEATURES;
        end else begin
          next_dual = 1'b1;
          next_res = R_SUCCESS;
        end
      end
      default: begin
      end
    endcase
  end

  // success clears both flags, no-block sets carry, recorded error sets zero
  logic flag_cf, flag_zf;
  assign flag_cf = res == R_FAIL_INVALID;
  assign flag_zf = res == R_FAIL_VALID;

  always_comb begin
    next_rd_data = 32'h0000_0000;
    if (rd_en) begin
      if (addr == REG_MODE) begin
        next_rd_data = mode;
      end else if (addr == REG_SEC_CAPS_HI) begin
        next_rd_data = sec_hi;
      end else if (addr == REG_TAG_CAPS_HI) begin
        next_rd_data = tag_hi;
      end else if (addr == REG_BASIC_CAPS_HI) begin
        next_rd_data = basic_hi;
      end else if (addr == REG_OP_LO) begin
        next_rd_data = op[31:0];
      end else if (addr == REG_OP_HI) begin
        next_rd_data = op[63:32];
      end else if (addr == REG_CUR_LO) begin
        next_rd_data = cur[31:0];
      end else if (addr == REG_CUR_HI) begin
        next_rd_data = cur[63:32];
      end else if (addr == REG_EN_LO) begin
        next_rd_data = en_ptr[31:0];
      end else if (addr == REG_EN_HI) begin
        next_rd_data = en_ptr[63:32];
      end else if (addr == REG_MONITOR_SEGMENT_REV) begin
        next_rd_data = monitor_segment_rev;
      end else if (addr == REG_STATUS) begin
        next_rd_data[ST_BUSY] = state != S_IDLE;
        next_rd_data[ST_DONE] = done_q;
        next_rd_data[ST_RES_LO +: 4] = res;
        next_rd_data[ST_CF] = flag_cf;
        next_rd_data[ST_ZF] = flag_zf;
        next_rd_data[ST_MGMT] = mgmt;
        next_rd_data[ST_DUAL] = dual;
        next_rd_data[ST_ERR_LO +: 8] = err;
        next_rd_data[ST_EXIT_LO +: 8] = exit_reason;
      end else if (addr == REG_LAUNCH) begin
        next_rd_data[0] = cur_launched;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      kind <= K_NONE;
      res <= R_NONE;
      err <= ERR_NONE;
      exit_reason <= 8'h00;
      done_q <= 1'b0;
      done_p <= 1'b0;
      mgmt <= 1'b0;
      dual <= 1'b0;
      mode <= MODE_RESET;
      sec_hi <= 32'h0000_0000;
      tag_hi <= 32'h0000_0000;
      basic_hi <= 32'h0000_0000;
      monitor_segment_rev <= 32'h0000_0000;
      op <= 64'h0000_0000_0000_0000;
      cur <= PTR_INVALID;
      en_ptr <= 64'h0000_0000_0000_0000;
      launched <= '0;
      rd_data <= 32'h0000_0000;
    end else begin
      state <= next_state;
      kind <= next_kind;
      res <= next_res;
      err <= next_err;
      exit_reason <= next_exit_reason;
      done_q <= next_done_q;
      done_p <= next_done_p;
      mgmt <= next_mgmt;
      dual <= next_dual;
      mode <= next_mode;
      sec_hi <= next_sec_hi;
      tag_hi <= next_tag_hi;
      basic_hi <= next_basic_hi;
      monitor_segment_rev <= next_monitor_segment_rev;
      op <= next_op;
      cur <= next_cur;
      en_ptr <= next_en_ptr;
      launched <= next_launched;
      rd_data <= next_rd_data;
    end
  end

  assign busy = state != S_IDLE;
  assign sys_mgmt_mode = mgmt;
  assign done = done_p;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic in_eval;
  assign in_eval = state == S_EVAL;

  tag_compat_ud_a: assert property (
    in_eval && kind == K_TAG && virt_on && compat |=> res == R_UD && done)
    else $error("tag invalidate in compat mode not undefined");
  tag_noncanon_a: assert property (
    in_eval && kind == K_TAG && ev_res != R_UD && !non_root && !cpl_nz && long64 &&
    ai.non_canon |=> res == ($past(mode[MODE_STACK_SEG]) ? R_SS : R_GP))
    else $error("tag invalidate non-canonical fault wrong");
  tag_caps_ud_a: assert property (
    in_eval && kind == K_TAG && !sec_hi[CAP_SEC_TAG_BIT] |=> res == R_UD)
    else $error("tag invalidate without capability not undefined");
  call_guest_exit_a: assert property (
    in_eval && kind == K_CALL && virt_on && non_root |=>
    res == R_VM_EXIT && exit_reason == EXIT_MONITOR_CALL && $stable(mgmt) && $stable(dual))
    else $error("guest monitor call did not exit");
  call_off_ud_a: assert property (
    in_eval && kind == K_CALL && !virt_on |=> res == R_UD)
    else $error("monitor call outside virtualization not undefined");
  call_dual_exit_a: assert property (
    in_eval && kind == K_CALL && ev_res == R_MGMT_EXIT |-> dual ##1 res == R_MGMT_EXIT)
    else $error("active dual monitor gave no management exit");
  call_revision_a: assert property (
    state == S_REV && monitor_segment_rev != MONITOR_SEGMENT_REVISION |=> !mgmt && res == R_FAIL_VALID && flag_zf)
    else $error("revision mismatch not failed");
  call_activate_a: assert property (
    in_eval && ev_to_rev && monitor_segment_rev == MONITOR_SEGMENT_REVISION |=> mgmt && state == S_REV ##1 mgmt ##1 done &&
    (dual == (res == R_SUCCESS)) && (mgmt == dual))
    else $error("activation sequence wrong");
  flush_clear_a: assert property (
    in_eval && kind == K_FLUSH && ev_res == R_SUCCESS |=> !launched[$past(op_slot)])
    else $error("flush left launch state set");
  flush_cur_inv_a: assert property (
    in_eval && kind == K_FLUSH && ev_res == R_SUCCESS && op == cur |=>
    cur == PTR_INVALID && !flag_cf && !flag_zf)
    else $error("flush of current block did not invalidate pointer");
  flush_enptr_a: assert property (
    in_eval && kind == K_FLUSH && ev_res != R_UD && !non_root && !cpl_nz &&
    !ai.bad_phys && op == en_ptr && !mode[MODE_PAGE_FAULT] && !ai.non_canon &&
    !mode[MODE_SEG_LIMIT] && !mode[MODE_SEG_UNUSABLE] && !mode[MODE_EXEC_ONLY] && cur_valid
    |=> err == ERR_FLUSH_ENPTR)
    else $error("flush of enable pointer not refused");

  call_success_c: cover property (state == S_FEAT && mode[MODE_FEAT_OK]);
  flush_success_c: cover property (in_eval && kind == K_FLUSH && ev_res == R_SUCCESS);
  guest_exit_c: cover property (in_eval && ev_res == R_VM_EXIT);
  fail_invalid_c: cover property (done && res == R_FAIL_INVALID);
endmodule : vcc_check_unit

// ### vcc_phys_chk.sv
// Purpose: flags a bad control-block physical address
// Assumes: pa_bits between 32 and 52
// Notes: 4 KB alignment, width limit, optional 32-bit limit
`timescale 1ns/1ps
module vcc_phys_chk (
  vcc_addr_if.phys a
);
  logic [63:0] high_mask;
  always_comb begin
    high_mask = PTR_MASK(a.pa_bits);
  end
  function automatic logic [63:0] PTR_MASK(input logic [6:0] bits);
    PTR_MASK = ~((64'h1 << bits) - 64'h1);
  endfunction : PTR_MASK
  // alignment and width; 32-bit limit when the capability asks for it
  assign a.bad_phys = (|a.addr[11:0]) || (|(a.addr & high_mask)) ||
                      (a.limit_32b && (|a.addr[63:32]));
endmodule : vcc_phys_chk

// ### vcc_pkg.sv
// Purpose: shared constants and types of the vm call / clear check unit
// Assumes: 32-bit register port, word offsets are byte addresses
// Notes: identity values here are arbitrary
package vcc_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_SEC_CAPS_HI = 8'h08;
  localparam logic [7:0] REG_TAG_CAPS_HI = 8'h0C;
  localparam logic [7:0] REG_BASIC_CAPS_HI = 8'h10;
  localparam logic [7:0] REG_OP_LO = 8'h14;
  localparam logic [7:0] REG_OP_HI = 8'h18;
  localparam logic [7:0] REG_CUR_LO = 8'h1C;
  localparam logic [7:0] REG_CUR_HI = 8'h20;
  localparam logic [7:0] REG_EN_LO = 8'h24;
  localparam logic [7:0] REG_EN_HI = 8'h28;
  localparam logic [7:0] REG_MONITOR_SEGMENT_REV = 8'h2C;
  localparam logic [7:0] REG_STATUS = 8'h30;
  localparam logic [7:0] REG_LAUNCH = 8'h34;
  // mode register fields
  localparam int MODE_VIRT_ON = 0;
  localparam int MODE_NON_ROOT = 1;
  localparam int MODE_PROT_EN = 2;
  localparam int MODE_V86 = 3;
  localparam int MODE_LMA = 4;
  localparam int MODE_CS_LONG = 5;
  localparam int MODE_CPL_LO = 6;
  localparam int MODE_SMM = 8;
  localparam int MODE_DUAL_SUP = 9;
  localparam int MODE_MONCTL_VALID = 10;
  localparam int MODE_REG_OPERAND = 11;
  localparam int MODE_STACK_SEG = 12;
  localparam int MODE_SEG_LIMIT = 13;
  localparam int MODE_SEG_UNUSABLE = 14;
  localparam int MODE_EXEC_ONLY = 15;
  localparam int MODE_PAGE_FAULT = 16;
  localparam int MODE_EXIT_CTL_OK = 17;
  localparam int MODE_FEAT_OK = 18;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  // capability bits inside the upper capability words
  localparam int CAP_SEC_TAG_BIT = 5;    // bit 37 overall
  localparam int CAP_TAG_INSTR_BIT = 0;  // bit 32 overall
  localparam int CAP_BASIC_32B_BIT = 16; // bit 48 overall
  // control register fields
  localparam int CTRL_KIND_LO = 0;
  localparam int CTRL_DUAL_CLR = 4;
  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_RES_LO = 2;
  localparam int ST_CF = 6;
  localparam int ST_ZF = 7;
  localparam int ST_MGMT = 8;
  localparam int ST_DUAL = 9;
  localparam int ST_ERR_LO = 16;
  localparam int ST_EXIT_LO = 24;
  localparam logic [63:0] PTR_INVALID = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [7:0] EXIT_MONITOR_CALL = 8'h12;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_CALL_ROOT = 8'h01;
  localparam logic [7:0] ERR_FLUSH_BADADDR = 8'h02;
  localparam logic [7:0] ERR_FLUSH_ENPTR = 8'h03;
  localparam logic [7:0] ERR_CALL_NONCLEAR = 8'h04;
  localparam logic [7:0] ERR_CALL_EXITCTL = 8'h05;
  localparam logic [7:0] ERR_CALL_MONITOR_SEGMENT_REV = 8'h06;
  localparam logic [7:0] ERR_CALL_FEATURES = 8'h07;
  typedef enum logic [1:0] {K_NONE, K_TAG, K_CALL, K_FLUSH} vcc_kind_e;
  typedef enum logic [3:0] {
    R_NONE, R_SUCCESS, R_FAIL_INVALID, R_FAIL_VALID, R_UD, R_GP, R_SS, R_PF,
    R_VM_EXIT, R_MGMT_EXIT
  } vcc_res_e;
endpackage : vcc_pkg

// ### vcc_sw_model.sv
// Purpose: software side issuing register accesses to the check unit
// Assumes: strobes one cycle long, never both at once
// Notes: drives right after a rising edge; the slave never stalls
`timescale 1ns/1ps
module vcc_sw_model (
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] addr,
  output logic [31:0] wr_data,
  output logic wr_en,
  output logic rd_en,
  input wire logic [31:0] rd_data
);
  initial begin
    addr = 8'h00;
    wr_data = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // data stands only in the cycle after the strobe; taken mid-cycle, well clear of edges
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rd_data;
  endtask : rd
endmodule : vcc_sw_model
